/* logic/mcr_regs.vh */
// Operation
// - Filter code 00 is off, 01/10/11 pick levels one to three; 00 at power-on.
// - Filter register fields: 7:6 local, 5:4 remote three, 3:2 two, 1:0 one.
// - Writing one to software reset bit 7 restores the power-on values of every configuration register.
// - Software reset location is write-only; reads give no stored value.
// - Maker, part and revision identifiers are read-only fixed codes, writes ignored.
// - Diode offsets hold six bits in 5:0, reset 3Dh, drive their channel.
// - Remote offsets hold four bits in 3:0, reset zero, drive their channel.
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define MCR_IDX_FAN3_PT3 8'ha7
`define MCR_IDX_FAN3_PT4 8'ha8
`define MCR_IDX_DIODE1_OFS 8'hc1
`define MCR_IDX_DIODE2_OFS 8'hc2
`define MCR_IDX_REMOTE1_OFS 8'hc4
`define MCR_IDX_REMOTE2_OFS 8'hc5
`define MCR_IDX_REMOTE3_OFS 8'hc6
`define MCR_IDX_FILTER_SEL 8'hcb
`define MCR_IDX_USER_TEMP1 8'he3
`define MCR_IDX_USER_TEMP2 8'he4
`define MCR_IDX_SOFT_RESET 8'hfc
`define MCR_IDX_MAKER_ID 8'hfd
`define MCR_IDX_PART_ID 8'hfe
`define MCR_IDX_REVISION_ID 8'hff

// ----------------------------------------
// Reset values and field layouts
// ----------------------------------------
`define MCR_RST_FAN3_PT3 8'hc8
`define MCR_RST_FAN3_PT4 8'he6
`define MCR_RST_DIODE_OFS 6'h3d
`define MCR_RST_REMOTE_OFS 4'h0
`define MCR_RST_FILTER_SEL 8'h00
`define MCR_RST_USER_TEMP 8'h00
`define MCR_DIODE_OFS_W 6
`define MCR_REMOTE_OFS_W 4
`define MCR_SOFT_RESET_BIT 7
`define MCR_FILT_LOCAL_HI 7
`define MCR_FILT_LOCAL_LO 6
`define MCR_FILT_R3_HI 5
`define MCR_FILT_R3_LO 4
`define MCR_FILT_R2_HI 3
`define MCR_FILT_R2_LO 2
`define MCR_FILT_R1_HI 1
`define MCR_FILT_R1_LO 0
`define MCR_FILT_OFF 2'h0
`define MCR_FILT_W 2
`define MCR_FILT_FIELDS 4

`endif

/* logic/mcr_config_id.v */
`timescale 1ns/1ns
`default_nettype none
`include "mcr_regs.vh"

module mcr_config_id #(
  // Identification codes: arbitrary neutral values
  parameter [7:0] MAKER_CODE = 8'h5a,
  parameter [7:0] PART_CODE = 8'h6b,
  parameter [7:0] REVISION_CODE = 8'h11
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Settings for the fan engine
  output reg [7:0] fan_table3_point3,
  output reg [7:0] fan_table3_point4,
  // Offsets for the measurement engine
  output reg [5:0] diode_one_offset,
  output reg [5:0] diode_two_offset,
  output reg [3:0] remote_one_offset,
  output reg [3:0] remote_two_offset,
  output reg [3:0] remote_three_offset,
  // Filter levels per source
  output reg [1:0] local_diode_filter_sel,
  output reg [1:0] remote_three_filter_sel,
  output reg [1:0] remote_two_filter_sel,
  output reg [1:0] remote_one_filter_sel,
  output reg filter_any_on,
  // User temperatures
  output reg [7:0] user_temp_one,
  output reg [7:0] user_temp_two,
  // Pulse to restart the rest of the device
  output reg soft_reset_pulse
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `MCR_IDX_FAN3_PT3, `MCR_IDX_FAN3_PT4, `MCR_IDX_DIODE1_OFS, `MCR_IDX_DIODE2_OFS,
        `MCR_IDX_REMOTE1_OFS, `MCR_IDX_REMOTE2_OFS, `MCR_IDX_REMOTE3_OFS,
        `MCR_IDX_FILTER_SEL, `MCR_IDX_USER_TEMP1, `MCR_IDX_USER_TEMP2,
        `MCR_IDX_SOFT_RESET, `MCR_IDX_MAKER_ID, `MCR_IDX_PART_ID,
        `MCR_IDX_REVISION_ID: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  wire [7:0] idx = paddr[9:2];
  // Upper address bits and misaligned addresses fall outside the map
  wire addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && mapped(idx);
  wire access = psel && penable && !pready;
  // Only byte lane zero carries register data
  wire wr = access && pwrite && addr_ok && pstrb[0];
  wire [7:0] wd = pwdata[7:0];
  // Software reset acts like power-on for every configuration register; bus response and filter summary registers use rst only
  wire soft_rst = wr && (idx == `MCR_IDX_SOFT_RESET) && wd[`MCR_SOFT_RESET_BIT];
  wire clear = rst || soft_rst;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [7:0] rd;
  always @* begin
    rd = 8'h00;
    case (idx)
      `MCR_IDX_FAN3_PT3: rd = fan_table3_point3;
      `MCR_IDX_FAN3_PT4: rd = fan_table3_point4;
      `MCR_IDX_DIODE1_OFS: rd = {2'h0, diode_one_offset};
      `MCR_IDX_DIODE2_OFS: rd = {2'h0, diode_two_offset};
      `MCR_IDX_REMOTE1_OFS: rd = {4'h0, remote_one_offset};
      `MCR_IDX_REMOTE2_OFS: rd = {4'h0, remote_two_offset};
      `MCR_IDX_REMOTE3_OFS: rd = {4'h0, remote_three_offset};
      `MCR_IDX_FILTER_SEL: rd = {local_diode_filter_sel, remote_three_filter_sel,
                                 remote_two_filter_sel, remote_one_filter_sel};
      `MCR_IDX_USER_TEMP1: rd = user_temp_one;
      `MCR_IDX_USER_TEMP2: rd = user_temp_two;
      `MCR_IDX_SOFT_RESET: rd = 8'h00;
      `MCR_IDX_MAKER_ID: rd = MAKER_CODE;
      `MCR_IDX_PART_ID: rd = PART_CODE;
      `MCR_IDX_REVISION_ID: rd = REVISION_CODE;
      default: rd = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Ready follows the first access cycle, so every transfer has one wait state
  wire rd_ok = access && !pwrite && addr_ok;
  wire bad_addr = access && !addr_ok;

  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // Error only outside the map; a dropped byte strobe is silently ignored
  always @(posedge clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= bad_addr;
    end
  end

  // Read data is zero outside the ready cycle, so stale values never leak
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else begin
      prdata <= rd_ok ? {24'h0, rd} : 32'h0;
    end
  end

  // One pulse per reset write, for the engines outside this bank
  always @(posedge clk) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_rst;
    end
  end

  // ----------------------------------------
  // Per-register write strobes
  // ----------------------------------------
  function hit;
    input [7:0] at;
    input [7:0] want;
    begin
      hit = (at == want);
    end
  endfunction

  // Identifier and reset locations get no strobe, so writes there store nothing
  wire wr_fan3_pt3 = wr && hit(idx, `MCR_IDX_FAN3_PT3);
  wire wr_fan3_pt4 = wr && hit(idx, `MCR_IDX_FAN3_PT4);
  wire wr_diode1 = wr && hit(idx, `MCR_IDX_DIODE1_OFS);
  wire wr_diode2 = wr && hit(idx, `MCR_IDX_DIODE2_OFS);
  wire wr_remote1 = wr && hit(idx, `MCR_IDX_REMOTE1_OFS);
  wire wr_remote2 = wr && hit(idx, `MCR_IDX_REMOTE2_OFS);
  wire wr_remote3 = wr && hit(idx, `MCR_IDX_REMOTE3_OFS);
  wire wr_filter = wr && hit(idx, `MCR_IDX_FILTER_SEL);
  wire wr_user1 = wr && hit(idx, `MCR_IDX_USER_TEMP1);
  wire wr_user2 = wr && hit(idx, `MCR_IDX_USER_TEMP2);

  // ----------------------------------------
  // Fan table three, output point three
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      fan_table3_point3 <= `MCR_RST_FAN3_PT3;
    end else if (wr_fan3_pt3) begin
      fan_table3_point3 <= wd;
    end
  end

  // ----------------------------------------
  // Fan table three, output point four
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      fan_table3_point4 <= `MCR_RST_FAN3_PT4;
    end else if (wr_fan3_pt4) begin
      fan_table3_point4 <= wd;
    end
  end

  // ----------------------------------------
  // Diode channel one offset
  // ----------------------------------------
  // Only six bits are stored, so reserved bits cannot reach the channel
  always @(posedge clk) begin
    if (clear) begin
      diode_one_offset <= `MCR_RST_DIODE_OFS;
    end else if (wr_diode1) begin
      diode_one_offset <= wd[`MCR_DIODE_OFS_W-1:0];
    end
  end

  // ----------------------------------------
  // Diode channel two offset
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      diode_two_offset <= `MCR_RST_DIODE_OFS;
    end else if (wr_diode2) begin
      diode_two_offset <= wd[`MCR_DIODE_OFS_W-1:0];
    end
  end

  // ----------------------------------------
  // Remote channel one offset
  // ----------------------------------------
  // Four stored bits; the upper nibble of a write is dropped on purpose
  always @(posedge clk) begin
    if (clear) begin
      remote_one_offset <= `MCR_RST_REMOTE_OFS;
    end else if (wr_remote1) begin
      remote_one_offset <= wd[`MCR_REMOTE_OFS_W-1:0];
    end
  end

  // ----------------------------------------
  // Remote channel two offset
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      remote_two_offset <= `MCR_RST_REMOTE_OFS;
    end else if (wr_remote2) begin
      remote_two_offset <= wd[`MCR_REMOTE_OFS_W-1:0];
    end
  end

  // ----------------------------------------
  // Remote channel three offset
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      remote_three_offset <= `MCR_RST_REMOTE_OFS;
    end else if (wr_remote3) begin
      remote_three_offset <= wd[`MCR_REMOTE_OFS_W-1:0];
    end
  end

  // ----------------------------------------
  // Filter level selectors
  // ----------------------------------------
  // Power-on code leaves every source unfiltered
  always @(posedge clk) begin
    if (clear) begin
      {local_diode_filter_sel, remote_three_filter_sel,
       remote_two_filter_sel, remote_one_filter_sel} <= `MCR_RST_FILTER_SEL;
    end else if (wr_filter) begin
      local_diode_filter_sel <= wd[`MCR_FILT_LOCAL_HI:`MCR_FILT_LOCAL_LO];
      remote_three_filter_sel <= wd[`MCR_FILT_R3_HI:`MCR_FILT_R3_LO];
      remote_two_filter_sel <= wd[`MCR_FILT_R2_HI:`MCR_FILT_R2_LO];
      remote_one_filter_sel <= wd[`MCR_FILT_R1_HI:`MCR_FILT_R1_LO];
    end
  end

  // ----------------------------------------
  // User temperature one
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      user_temp_one <= `MCR_RST_USER_TEMP;
    end else if (wr_user1) begin
      user_temp_one <= wd;
    end
  end

  // ----------------------------------------
  // User temperature two
  // ----------------------------------------
  always @(posedge clk) begin
    if (clear) begin
      user_temp_two <= `MCR_RST_USER_TEMP;
    end else if (wr_user2) begin
      user_temp_two <= wd;
    end
  end

  // ----------------------------------------
  // Filter activity summary
  // ----------------------------------------
  wire [7:0] filter_word = {local_diode_filter_sel, remote_three_filter_sel,
                            remote_two_filter_sel, remote_one_filter_sel};
  wire [`MCR_FILT_FIELDS-1:0] field_on;

  genvar f;
  generate
    for (f = 0; f < `MCR_FILT_FIELDS; f = f + 1) begin : g_field_on
      assign field_on[f] = (filter_word[f*`MCR_FILT_W+1 -: `MCR_FILT_W] != `MCR_FILT_OFF);
    end
  endgenerate

  // Registered so the filter engine can power down when every source is off;
  // it lags the selectors by one cycle, which the engine tolerates
  always @(posedge clk) begin
    if (rst) begin
      filter_any_on <= 1'b0;
    end else begin
      filter_any_on <= |field_on;
    end
  end

endmodule // mcr_config_id
`default_nettype wire

/* verification/mcr_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host software seen as an APB master
// ----------------------------------------
module mcr_host (
  input wire logic clk,
  input wire logic pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // One edge first, so a release and the next setup never share a time step
  task xfer(input logic w, input logic [7:0] idx, d, output logic [7:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    pstrb <= 4'h1;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    {psel, penable} <= 2'h0;
    // Released lines must not keep looking valid
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // mcr_host
`default_nettype wire

/* verification/mcr_config_id_props.sv */
`timescale 1ns/1ns
`default_nettype none
module mcr_config_id_props #(parameter [7:0] MAKER_CODE = 8'h5a) (
  input wire logic clk, rst, psel, penable, pwrite, pready, soft_reset_pulse,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic [5:0] diode_one_offset, diode_two_offset,
  input wire logic [3:0] remote_one_offset, remote_three_offset,
  input wire logic [1:0] local_diode_filter_sel, remote_one_filter_sel,
  input wire logic [1:0] remote_two_filter_sel, remote_three_filter_sel,
  input wire logic filter_any_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable && !pready;
  wire logic wr = acc && pwrite && pstrb[0];
  wire logic rd = acc && !pwrite;
  logic [7:0] last_wd;
  always_ff @(posedge clk) last_wd <= pwdata[7:0];
  chk_rst_diode: assert property ($fell(rst) |-> diode_one_offset == 6'h3d)
    else $error("diode offset not at default");
  chk_rst_remote: assert property ($fell(rst) |-> remote_three_offset == 4'h0)
    else $error("remote offset not at default");
  chk_rst_filter: assert property ($fell(rst) |-> local_diode_filter_sel == 2'h0)
    else $error("filter not off after reset");
  chk_filter_wr: assert property (wr && paddr == 12'h32c |=>
    local_diode_filter_sel == last_wd[7:6] && remote_one_filter_sel == last_wd[1:0])
    else $error("filter fields misplaced");
  chk_diode_wr: assert property (wr && paddr == 12'h304 |=> diode_one_offset == last_wd[5:0])
    else $error("diode offset not written");
  chk_remote_wr: assert property (wr && paddr == 12'h310 |=> remote_one_offset == last_wd[3:0])
    else $error("remote offset not written");
  chk_soft_reset: assert property (wr && paddr == 12'h3f0 && pwdata[7] |=>
    soft_reset_pulse && diode_two_offset == 6'h3d)
    else $error("soft reset had no effect");
  chk_soft_other: assert property (wr && paddr == 12'h3f0 && !pwdata[7] |=> !soft_reset_pulse)
    else $error("reserved bit caused reset");
  chk_reset_read: assert property (rd && paddr == 12'h3f0 |=> pready && prdata == 32'h0)
    else $error("reset location read nonzero");
  chk_maker_read: assert property (rd && paddr == 12'h3f4 |=> prdata == {24'h0, MAKER_CODE})
    else $error("maker code wrong");
  chk_filter_summary: assert property (filter_any_on == $past(|{local_diode_filter_sel,
    remote_three_filter_sel, remote_two_filter_sel, remote_one_filter_sel}))
    else $error("filter summary wrong");
endmodule // mcr_config_id_props
`default_nettype wire

/* verification/mcr_config_id_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module mcr_config_id_tb;
  logic clk = 0, rst = 1, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] r;
  int fails = 0, samples_checked = 0;
  logic [7:0] idx_t [10] = '{8'ha7, 8'ha8, 8'hc1, 8'hc2, 8'hc4, 8'hc5, 8'hc6, 8'hcb, 8'he3, 8'he4};
  logic [7:0] def_t [10] = '{8'hc8, 8'he6, 8'h3d, 8'h3d, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
  logic [7:0] msk_t [10] = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'hf, 8'hf, 8'hf, 8'hff, 8'hff, 8'hff};
  mcr_host host (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb);
  // Identification codes: arbitrary values
  mcr_config_id #(.MAKER_CODE(8'h5a), .PART_CODE(8'h6b), .REVISION_CODE(8'h11)) uut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .fan_table3_point3(), .fan_table3_point4(), .diode_one_offset(), .diode_two_offset(),
    .remote_one_offset(), .remote_two_offset(), .remote_three_offset(), .filter_any_on(),
    .local_diode_filter_sel(), .remote_three_filter_sel(), .remote_two_filter_sel(),
    .remote_one_filter_sel(), .user_temp_one(), .user_temp_two(), .soft_reset_pulse());
  task automatic rd(input logic [7:0] idx, want, input logic err);
    host.xfer(1'b0, idx, 8'h0, r, e);
    `CHK(r, want)
    `CHK(e, err)
  endtask
  task automatic wr(input logic [7:0] idx, d);
    host.xfer(1'b1, idx, d, r, e);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_defaults;
    foreach (idx_t[i]) rd(idx_t[i], def_t[i], 1'b0);
    $display("defaults done");
  endtask
  task test_masks;
    foreach (idx_t[i]) begin
      wr(idx_t[i], 8'hff);
      rd(idx_t[i], msk_t[i], 1'b0);
    end
    $display("masks done");
  endtask
  task test_filter;
    for (int c = 0; c < 4; c++) begin
      wr(8'hcb, {4{c[1:0]}});
      rd(8'hcb, {4{c[1:0]}}, 1'b0);
    end
    wr(8'hcb, 8'h1b);
    rd(8'hcb, 8'h1b, 1'b0);
    $display("filter done");
  endtask
  task test_ids;
    wr(8'hfd, 8'hff);
    rd(8'hfd, 8'h5a, 1'b0);
    wr(8'hfe, 8'h00);
    rd(8'hfe, 8'h6b, 1'b0);
    rd(8'hff, 8'h11, 1'b0);
    rd(8'hfc, 8'h00, 1'b0);
    rd(8'h00, 8'h00, 1'b1);
    $display("ids done");
  endtask
  task test_soft;
    wr(8'hc1, 8'h10);
    wr(8'hfc, 8'h7f);
    rd(8'hc1, 8'h10, 1'b0);
    wr(8'hfc, 8'h80);
    rd(8'hc1, 8'h3d, 1'b0);
    rd(8'hcb, 8'h00, 1'b0);
    $display("soft reset done");
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_defaults();
    test_masks();
    test_filter();
    test_ids();
    test_soft();
    print_verdict();
  end
  // Whole run needs about 2 us
  initial begin
    #50000;
    fails++;
    print_verdict();
  end
endmodule // mcr_config_id_tb
bind mcr_config_id mcr_config_id_props #(.MAKER_CODE(MAKER_CODE)) chk (.clk, .rst, .psel,
  .penable, .pwrite, .pready, .soft_reset_pulse, .paddr, .pwdata, .prdata, .pstrb,
  .diode_one_offset, .diode_two_offset, .remote_one_offset, .remote_three_offset,
  .local_diode_filter_sel, .remote_one_filter_sel, .remote_two_filter_sel,
  .remote_three_filter_sel, .filter_any_on);
`default_nettype wire
